// *** cmt_top.sv ***
// Output compare timer: divided count source, 8-bit match counter, pin out.
module cmt_top
  import cmt_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                src_tick,
  input  wire cmt_sw_t             sw,
  input  wire cmt_cfg_t            cfg,
  input  wire cmt_clks_t           clks,
  output cmt_stat_t                stat,
  output logic                     match_irq,
  output logic     [CMT_PINS-1:0]  pin_out,
  output logic     [CMT_PINS-1:0]  pin_oe_n
);

  cmt_state_t     state_r;
  cmt_state_t     state_nxt;
  logic           start_r;
  logic           start_nxt;
  logic           srst_r;
  logic           srst_nxt;
  logic [7:0]     cnt_r;
  logic [7:0]     cnt_nxt;
  logic [7:0]     cmp_r;
  logic [7:0]     cmp_nxt;
  logic           tgl_r;
  logic           tgl_nxt;
  logic           irq_r;
  logic           irq_nxt;
  logic           ck_r;
  logic           ck_nxt;
  logic           soft_clr;
  logic           running;
  logic           half_tick;
  logic           pre_tick;
  logic           cnt_tick;
  logic           match;
  logic           cmp_wr_ok;
  logic           pin_level;
  logic           pin_drive;

  // Soft reset acts on the falling write of the bit, after it was set.
  assign soft_clr = sw.rst_wr & ~sw.rst_wdata & srst_r;
  assign running  = (state_r == CMT_ST_RUN);

  // First stage halves the source; it only moves while counting so that
  // a stopped timer resumes with its phase intact.
  cmt_divider #(
    .W        (CMT_DIV_W)
  ) u_half (
    .clk      (clk),
    .rst_n    (rst_n),
    .clr      (soft_clr),
    .tick_in  (src_tick & running),
    .tick_out (half_tick)
  );

  // Optional sixteen-fold prescale stage.
  cmt_divider #(
    .W        (CMT_PRE_W)
  ) u_pre (
    .clk      (clk),
    .rst_n    (rst_n),
    .clr      (soft_clr),
    .tick_in  (half_tick & cfg.prescale_counter_select),
    .tick_out (pre_tick)
  );

  // Counting clock is 2 or 32 source ticks.
  assign cnt_tick = cfg.prescale_counter_select ? pre_tick : half_tick;
  assign match    = cnt_tick & (cnt_r == cmp_r);

  // The compare value may change only while both start and status are low.
  assign cmp_wr_ok = sw.cmp_wr & ~start_r & ~running;

  // Control: start bit, soft reset bit and run state. Status follows the
  // start bit on the next source tick, as the count domain sees it.
  always_comb
  begin
    start_nxt = start_r;
    srst_nxt  = srst_r;
    state_nxt = state_r;
    if (sw.rst_wr)
    begin
      srst_nxt = sw.rst_wdata;
    end
    if (sw.start_wr)
    begin
      start_nxt = sw.start_wdata;
    end
    unique case (state_r)
      CMT_ST_STOP:
      begin
        if (src_tick && start_r)
        begin
          state_nxt = CMT_ST_RUN;
        end
      end
      CMT_ST_RUN:
      begin
        if (src_tick && !start_r)
        begin
          state_nxt = CMT_ST_STOP;
        end
      end
      default:
      begin
        state_nxt = CMT_ST_STOP;
      end
    endcase
    if (soft_clr)
    begin
      start_nxt = 1'b0;
      state_nxt = CMT_ST_STOP;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      start_r <= 1'b0;
      srst_r  <= 1'b0;
      state_r <= CMT_ST_STOP;
    end
    else
    begin
      start_r <= start_nxt;
      srst_r  <= srst_nxt;
      state_r <= state_nxt;
    end
  end

  // Counter, compare value, toggle and request. There is no write path to
  // the counter, so only a soft reset can disturb a running count.
  always_comb
  begin
    cnt_nxt = cnt_r;
    cmp_nxt = cmp_r;
    tgl_nxt = tgl_r;
    irq_nxt = 1'b0;
    if (match)
    begin
      cnt_nxt = CMT_CNT_RST;
      irq_nxt = cfg.match_irq_enable;
      if (cfg.compare_out_select)
      begin
        tgl_nxt = ~tgl_r;
      end
    end
    else if (cnt_tick)
    begin
      cnt_nxt = cnt_r + 8'h01;
    end
    if (cmp_wr_ok)
    begin
      cmp_nxt = sw.cmp_wdata;
    end
    if (soft_clr)
    begin
      cnt_nxt = CMT_CNT_RST;
      cmp_nxt = CMT_CMP_RST;
      tgl_nxt = 1'b0;
      irq_nxt = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= CMT_CNT_RST;
      cmp_r <= CMT_CMP_RST;
      tgl_r <= 1'b0;
      irq_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      cmp_r <= cmp_nxt;
      tgl_r <= tgl_nxt;
      irq_r <= irq_nxt;
    end
  end

  // Clock output select. The selected source is retimed into ck_r, so the pin changes
  // only on clk edges; a selection change while enabled switches ck_r at the next edge and the pin at the edge after.
  always_comb
  begin
    ck_nxt = 1'b0;
    unique case (cfg.clock_out_select)
      CMT_CKSEL_F2:  ck_nxt = clks.clk_f2;
      CMT_CKSEL_SUB: ck_nxt = clks.subclock;
      CMT_CKSEL_F4:  ck_nxt = clks.clk_f4;
      CMT_CKSEL_F8:  ck_nxt = clks.clk_f8;
      default:       ck_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ck_r <= 1'b0;
    end
    else
    begin
      ck_r <= ck_nxt;
    end
  end

  // Pin function: clock output first, then compare toggle, else the pin
  // is left to the port logic and the timer does not drive it.
  always_comb
  begin
    pin_level = cfg.gpio_level;
    pin_drive = 1'b0;
    if (cfg.clock_out_enable)
    begin
      pin_level = ck_r;
      pin_drive = 1'b1;
    end
    else if (cfg.compare_out_select)
    begin
      pin_level = tgl_r;
      pin_drive = 1'b1;
    end
  end

  cmt_pin_route u_route (
    .clk      (clk),
    .rst_n    (rst_n),
    .level    (pin_level),
    .drive    (pin_drive),
    .route    ({cfg.pin_route_bit_b, cfg.pin_route_bit_a}),
    .pin_out  (pin_out),
    .pin_oe_n (pin_oe_n)
  );

  // Readable state comes straight from the registers.
  always_comb
  begin
    stat.count_start_bit   = start_r;
    stat.count_status_flag = running;
    stat.soft_reset_bit    = srst_r;
    stat.counter_read_reg  = cnt_r;
    stat.compare_value_reg = cmp_r;
  end
  assign match_irq = irq_r;

  // Checks.
  a_match_reload: assert property (@(posedge clk) disable iff (!rst_n)
    match |=> cnt_r == CMT_CNT_RST)
    else $error("counter did not reload zero on match");

  a_count_step: assert property (@(posedge clk) disable iff (!rst_n)
    cnt_tick && !match && !soft_clr |=> cnt_r == $past(cnt_r) + 8'h01)
    else $error("counter did not step on count tick");

  a_stop_hold: assert property (@(posedge clk) disable iff (!rst_n)
    !running && !soft_clr |=> $stable(cnt_r) && $stable(tgl_r))
    else $error("stopped timer changed count or output");

  a_irq_cause: assert property (@(posedge clk) disable iff (!rst_n)
    irq_r == $past(match && cfg.match_irq_enable && !soft_clr))
    else $error("interrupt request not tied to enabled match");

  a_toggle_flip: assert property (@(posedge clk) disable iff (!rst_n)
    match && cfg.compare_out_select && !soft_clr |=> tgl_r != $past(tgl_r))
    else $error("compare output did not invert on match");

  a_cmp_guard: assert property (@(posedge clk) disable iff (!rst_n)
    (start_r || running) && !soft_clr |=> $stable(cmp_r))
    else $error("compare value changed while timer active");

  a_soft_clear: assert property (@(posedge clk) disable iff (!rst_n)
    soft_clr |=> cnt_r == CMT_CNT_RST && cmp_r == CMT_CMP_RST && !tgl_r
      && !start_r && !running)
    else $error("soft reset left timer state");

  a_start_run: assert property (@(posedge clk) disable iff (!rst_n)
    sw.start_wr && sw.start_wdata && !soft_clr
      ##1 src_tick && start_r && !soft_clr |=> running)
    else $error("status did not follow start bit");

  a_half_rate: assert property (@(posedge clk) disable iff (!rst_n)
    half_tick |-> !$past(half_tick))
    else $error("halved count source ticked twice in a row");

endmodule // cmt_top

// *** cmt_pkg.sv ***
// Shared constants and carrier types for the compare match timer.
package cmt_pkg;

  // Counter widths and pin count.
  localparam int CMT_CNT_W = 8;
  localparam int CMT_PRE_W = 4;
  localparam int CMT_DIV_W = 1;
  localparam int CMT_PINS  = 3;

  // Values after reset, hardware or software.
  localparam logic [7:0] CMT_CNT_RST = 8'h00;
  localparam logic [7:0] CMT_CMP_RST = 8'h00;
  localparam logic [3:0] CMT_PRE_RST = 4'h0;
  localparam logic [0:0] CMT_DIV_RST = 1'h0;

  // Clock output selection codes, {msb, mid, lsb}.
  localparam logic [2:0] CMT_CKSEL_F2  = 3'h0;
  localparam logic [2:0] CMT_CKSEL_SUB = 3'h1;
  localparam logic [2:0] CMT_CKSEL_F4  = 3'h2;
  localparam logic [2:0] CMT_CKSEL_F8  = 3'h4;

  // Pin route codes, {pin_route_bit_b, pin_route_bit_a}.
  localparam logic [1:0] CMT_ROUTE_P0 = 2'h0;
  localparam logic [1:0] CMT_ROUTE_P1 = 2'h1;
  localparam logic [1:0] CMT_ROUTE_P2 = 2'h2;

  // Run state of the counter.
  typedef enum logic [1:0] {
    CMT_ST_STOP = 2'b01,
    CMT_ST_RUN  = 2'b10
  } cmt_state_t;

  // Software write strobes with their data.
  typedef struct packed {
    logic       start_wr;
    logic       start_wdata;
    logic       cmp_wr;
    logic [7:0] cmp_wdata;
    logic       rst_wr;
    logic       rst_wdata;
  } cmt_sw_t;

  // Static configuration levels.
  typedef struct packed {
    logic       prescale_counter_select;
    logic       match_irq_enable;
    logic       clock_out_enable;
    logic [2:0] clock_out_select;
    logic       compare_out_select;
    logic       pin_route_bit_a;
    logic       pin_route_bit_b;
    logic       gpio_level;
  } cmt_cfg_t;

  // Internal clocks offered on the output pin, as sampled levels.
  typedef struct packed {
    logic clk_f2;
    logic subclock;
    logic clk_f4;
    logic clk_f8;
  } cmt_clks_t;

  // Readable state.
  typedef struct packed {
    logic       count_start_bit;
    logic       count_status_flag;
    logic       soft_reset_bit;
    logic [7:0] counter_read_reg;
    logic [7:0] compare_value_reg;
  } cmt_stat_t;

endpackage

// *** cmt_divider.sv ***
// Free divider stage that passes every 2**W-th input tick.
module cmt_divider
  import cmt_pkg::*;
#(
  parameter int W = 1
)
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic clr,
  input  wire logic tick_in,
  output logic      tick_out
);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Count input ticks; a clear wins because it comes from a timer reset.
  always_comb
  begin
    cnt_nxt = cnt_r;
    if (clr)
    begin
      cnt_nxt = '0;
    end
    else if (tick_in)
    begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cnt_r <= '0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
    end
  end

  // Pass the tick that wraps the stage.
  assign tick_out = tick_in & (&cnt_r) & ~clr;

endmodule // cmt_divider

// *** cmt_pin_route.sv ***
// Routes the timer output level to one of three candidate port pins.
module cmt_pin_route
  import cmt_pkg::*;
(
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                level,
  input  wire logic                drive,
  input  wire logic [1:0]          route,
  output logic     [CMT_PINS-1:0]  pin_out,
  output logic     [CMT_PINS-1:0]  pin_oe_n
);

  logic [CMT_PINS-1:0] out_nxt;
  logic [CMT_PINS-1:0] oe_n_nxt;

  // Only the selected pin is driven; the others stay with the port logic.
  always_comb
  begin
    out_nxt  = '0;
    oe_n_nxt = '1;
    unique case (route)
      CMT_ROUTE_P0:
      begin
        out_nxt[0]  = level;
        oe_n_nxt[0] = ~drive;
      end
      CMT_ROUTE_P1:
      begin
        out_nxt[1]  = level;
        oe_n_nxt[1] = ~drive;
      end
      CMT_ROUTE_P2:
      begin
        out_nxt[2]  = level;
        oe_n_nxt[2] = ~drive;
      end
      default:
      begin
        out_nxt  = '0;
        oe_n_nxt = '1;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_out  <= '0;
      pin_oe_n <= '1;
    end
    else
    begin
      pin_out  <= out_nxt;
      pin_oe_n <= oe_n_nxt;
    end
  end

endmodule // cmt_pin_route

// *** tb_top.sv ***
// Self-checking bench for the compare match timer.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import cmt_pkg::*;

  logic       clk;
  logic       rst_n;
  logic       src_tick;
  logic       tick_en;
  cmt_sw_t    sw;
  cmt_cfg_t   cfg;
  cmt_clks_t  clks;
  cmt_stat_t  stat;
  logic       match_irq;
  logic [2:0] pin_out;
  logic [2:0] pin_oe_n;
  int         tick_cnt;
  int         cyc;
  int         error_cnt;
  int         total_checks;

  cmt_top dut_u (
    .clk       (clk),
    .rst_n     (rst_n),
    .src_tick  (src_tick),
    .sw        (sw),
    .cfg       (cfg),
    .clks      (clks),
    .stat      (stat),
    .match_irq (match_irq),
    .pin_out   (pin_out),
    .pin_oe_n  (pin_oe_n)
  );

  // Free running 100 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Ticks every other cycle; ticks are counted from one request to the next.
  always @(posedge clk)
  begin
    src_tick <= tick_en & ~src_tick;
    tick_cnt <= match_irq ? int'(src_tick) : tick_cnt + int'(src_tick);
    cyc      <= cyc + 1;
    if (cyc == 30000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d, errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask

  // One write strobe; returns once the written field has settled.
  task automatic wr(int kind, logic [7:0] d);
    cmt_sw_t v;
    v = '0;
    case (kind)
      0: {v.start_wr, v.start_wdata} = {1'b1, d[0]};
      1: {v.cmp_wr, v.cmp_wdata} = {1'b1, d};
      default: {v.rst_wr, v.rst_wdata} = {1'b1, d[0]};
    endcase
    @(posedge clk);
    sw <= v;
    @(posedge clk);
    sw <= '0;
    @(posedge clk);
    #1;
  endtask

  // Bounded wait, long enough for the slowest period used here.
  task automatic wait_irq();
    int i;
    i = 0;
    do
    begin
      @(posedge clk);
      #1;
      i++;
    end
    while (match_irq !== 1'b1 && i < 1200);
    chk("irq seen", 1, match_irq);
  endtask

  // Two match periods, then a stop that must freeze the state.
  task automatic period(logic [7:0] n, logic pre);
    logic [7:0] c;
    logic       p;
    @(posedge clk);
    cfg.prescale_counter_select <= pre;
    wr(1, n);
    chk("compare value", n, stat.compare_value_reg);
    wr(0, 8'h01);
    wait_irq();
    chk("start bit", 1, stat.count_start_bit);
    chk("status flag", 1, stat.count_status_flag);
    wait_irq();
    chk("ticks per match", (pre ? 32 : 2) * (n + 1), tick_cnt);
    chk("counter at match", 0, stat.counter_read_reg);
    p = pin_out[0];
    @(posedge clk);
    #1;
    chk("toggle level", !p, pin_out[0]);
    wr(1, ~n);
    chk("compare locked", n, stat.compare_value_reg);
    wr(0, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    c = stat.counter_read_reg;
    p = pin_out[0];
    chk("status flag", 0, stat.count_status_flag);
    repeat (40) @(posedge clk);
    #1;
    chk("held counter", c, stat.counter_read_reg);
    chk("held level", p, pin_out[0]);
  endtask

  // Matches keep happening but no request may reach the output.
  task automatic irq_off();
    int seen;
    seen = 0;
    @(posedge clk);
    cfg.match_irq_enable <= 1'b0;
    wr(0, 8'h01);
    repeat (60)
    begin
      @(posedge clk);
      #1;
      if (match_irq !== 1'b0)
        seen++;
    end
    chk("masked irq", 0, seen);
    wr(0, 8'h00);
    @(posedge clk);
    cfg.match_irq_enable <= 1'b1;
  endtask

  task automatic soft_rst();
    wr(0, 8'h01);
    repeat (30) @(posedge clk);
    wr(2, 8'h01);
    chk("reset bit", 1, stat.soft_reset_bit);
    wr(2, 8'h00);
    chk("reset bit", 0, stat.soft_reset_bit);
    chk("counter", 0, stat.counter_read_reg);
    chk("compare", 0, stat.compare_value_reg);
    chk("start bit", 0, stat.count_start_bit);
    chk("status flag", 0, stat.count_status_flag);
    chk("toggle level", 0, pin_out[0]);
  endtask

  // Each clock code in turn on routes 0, 1, 2, 0; select moves only while disabled.
  task automatic clock_out();
    logic [2:0] code [4];
    logic [2:0] oe_exp;
    int         r;
    code = '{CMT_CKSEL_F2, CMT_CKSEL_SUB, CMT_CKSEL_F4, CMT_CKSEL_F8};
    for (int k = 0; k < 4; k++)
    begin
      r = k % 3;
      @(posedge clk);
      cfg.clock_out_enable <= 1'b0;
      @(posedge clk);
      cfg.clock_out_select <= code[k];
      cfg.pin_route_bit_a <= r[0];
      cfg.pin_route_bit_b <= r[1];
      clks <= cmt_clks_t'(4'h8 >> k);
      @(posedge clk);
      cfg.clock_out_enable <= 1'b1;
      repeat (4) @(posedge clk);
      #1;
      oe_exp = ~(3'h1 << r);
      chk("pin enables", oe_exp, pin_oe_n);
      chk("clock level", 1, pin_out[r]);
      @(posedge clk);
      clks <= '0;
      repeat (4) @(posedge clk);
      #1;
      chk("clock level", 0, pin_out[r]);
    end
    @(posedge clk);
    cfg.clock_out_enable <= 1'b0;
    cfg.compare_out_select <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk("port mode", 3'h7, pin_oe_n);
    @(posedge clk);
    cfg.compare_out_select <= 1'b1;
    cfg.pin_route_bit_a <= 1'b0;
    cfg.pin_route_bit_b <= 1'b0;
  endtask

  // Main sequence: reset, then one scenario after another.
  initial
  begin
    rst_n = 1'b0;
    sw = '0;
    cfg = '0;
    cfg.compare_out_select = 1'b1;
    cfg.match_irq_enable = 1'b1;
    clks = '0;
    src_tick = 1'b0;
    tick_en = 1'b0;
    tick_cnt = 0;
    cyc = 0;
    error_cnt = 0;
    total_checks = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    tick_en <= 1'b1;
    @(posedge clk);
    #1;
    chk("status after reset", 0, stat);
    chk("pins after reset", 0, {match_irq, pin_out});
    period(8'h00, 1'b0);
    period(8'hff, 1'b0);
    period(8'h02, 1'b1);
    period(8'h03, 1'b0);
    irq_off();
    soft_rst();
    clock_out();
    print_verdict();
  end

endmodule // tb_top
